//--- logic/swd_pkg.sv
// constants and types shared by the system watchdog timer
// Operation
// - 32-bit down counter on always-on bus clock
// - decrement by one each cycle while running
// - sixteen power-of-two periods, 4-bit index
// - load value is 2^(16+i) minus one
// - initial period first, restart period afterwards
// - initial index from its own range field
// - restart index from separate range field
// - valid restart write reloads restart period
// - counter reaching zero is a timeout
// - reset mode raises reset request on timeout
// - interrupt mode raises interrupt and reloads
// - unserviced second timeout raises reset request
// - restart at zero suppresses the interrupt
// - after timeout reload and keep counting
// - pause input holds the counter
// - outputs: interrupt and reset request lines
// - reset leaves the watchdog disabled
// - once enabled, disable attempts are ignored
// - counting independent of clock manager loops
// - besides a timeout, only restart key 0x76 or an interrupt clear read reloads
// - mode bit 0 reset, 1 interrupt
// - writing enable one starts counting
// - interrupt clear read reloads like restart
package swd_pkg;
    localparam int          SWD_CNT_W       = 32;
    localparam int          SWD_TOP_W       = 4;
    localparam int          SWD_KEY_W       = 8;
    localparam int          SWD_TOP_BASE    = 16;
    localparam logic [7:0]  SWD_RESTART_KEY = 8'h76;
    localparam logic [31:0] SWD_CNT_RST     = 32'h0000_0000;
    localparam logic        SWD_MODE_RESET  = 1'b0;
    localparam logic        SWD_MODE_IRQ    = 1'b1;

    typedef enum logic [2:0] {
        SWD_DISABLED = 3'b001,
        SWD_FIRST    = 3'b010,
        SWD_SECOND   = 3'b100
    } swd_state_e;
endpackage

//--- logic/swd_period_lut.sv
// period index to counter load value
`timescale 1ns/1ps
module swd_period_lut
    import swd_pkg::*;
(
    input  wire logic [SWD_TOP_W-1:0] top_i,
    output logic      [SWD_CNT_W-1:0] load_o
);
    // 2^(16+i)-1 as a mask of ones
    always_comb
    begin
        load_o = (SWD_CNT_W'(1) << (SWD_TOP_BASE + int'(top_i))) - SWD_CNT_W'(1);
    end
endmodule // swd_period_lut

//--- logic/swd_pause_sync.sv
// three-stage synchroniser for the debug pause pin
`timescale 1ns/1ps
module swd_pause_sync
    import swd_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    input  wire logic async_i,
    output logic      level_o
);
    typedef struct packed {
        logic [2:0] stg;
        logic       level;
    } swd_sync_s;

    swd_sync_s r;
    swd_sync_s next_r;

    // stage 0 feeds only stage 1; change counts once stages 1 and 2 agree
    always_comb
    begin
        next_r = r;
        next_r.stg = {r.stg[1:0], async_i};
        if (r.stg[1] == r.stg[2])
        begin
            next_r.level = r.stg[2];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign level_o = r.level;
endmodule // swd_pause_sync

//--- logic/swd_watchdog.sv
// system watchdog timer core
`timescale 1ns/1ps
module swd_watchdog
    import swd_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 srst_i,
    input  wire logic                 enable_wr_i,
    input  wire logic                 enable_val_i,
    input  wire logic                 mode_i,
    input  wire logic [SWD_TOP_W-1:0] top_init_i,
    input  wire logic [SWD_TOP_W-1:0] top_i,
    input  wire logic                 restart_wr_i,
    input  wire logic [SWD_KEY_W-1:0] restart_data_i,
    input  wire logic                 eoi_rd_i,
    input  wire logic                 pause_i,
    output logic                      enabled_o,
    output logic      [SWD_CNT_W-1:0] count_o,
    output logic                      irq_o,
    output logic                      rst_req_o
);
    typedef struct packed {
        swd_state_e           st;
        logic [SWD_CNT_W-1:0] cnt;
        logic                 irq;
        logic                 rst_req;
    } swd_core_s;

    swd_core_s r;
    swd_core_s next_r;

    logic [SWD_CNT_W-1:0] init_load;
    logic [SWD_CNT_W-1:0] restart_load;
    logic                 paused;
    logic                 kick;
    logic                 at_zero;

    swd_period_lut u_init_lut (
        .top_i  (top_init_i),
        .load_o (init_load)
    );

    swd_period_lut u_restart_lut (
        .top_i  (top_i),
        .load_o (restart_load)
    );

    // the pin may come from another domain, so it is always synchronised
    swd_pause_sync u_pause (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .async_i   (pause_i),
        .level_o   (paused)
    );

    // besides a timeout, only the key or an interrupt clear read reloads, guarding against stray writes
    assign kick = (restart_wr_i && restart_data_i == SWD_RESTART_KEY) || eoi_rd_i;
    assign at_zero = (r.cnt == SWD_CNT_RST);

    always_comb
    begin
        next_r = r;
        case (r.st)
            SWD_DISABLED:
            begin
                if (enable_wr_i && enable_val_i)
                begin
                    next_r.st  = SWD_FIRST;
                    next_r.cnt = init_load;
                end
            end
            SWD_FIRST, SWD_SECOND:
            begin
                // disable writes are not looked at here at all
                if (kick)
                begin
                    next_r.cnt = restart_load;
                    next_r.irq = 1'b0;
                    next_r.st  = SWD_FIRST;
                end
                else if (at_zero)
                begin
                    next_r.cnt = restart_load;
                    if (mode_i == SWD_MODE_RESET || r.st == SWD_SECOND)
                    begin
                        next_r.rst_req = 1'b1;
                    end
                    else
                    begin
                        next_r.irq = 1'b1;
                        next_r.st  = SWD_SECOND;
                    end
                end
                else if (!paused)
                begin
                    next_r.cnt = r.cnt - SWD_CNT_W'(1);
                end
            end
            default:
            begin
                next_r.st = SWD_DISABLED;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            r.st      <= SWD_DISABLED;
            r.cnt     <= SWD_CNT_RST;
            r.irq     <= 1'b0;
            r.rst_req <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign enabled_o = (r.st != SWD_DISABLED);
    assign count_o   = r.cnt;
    assign irq_o     = r.irq;
    assign rst_req_o = r.rst_req;

    property p_enable_loads;
        @(posedge clk_sys_i) disable iff (srst_i)
        (r.st == SWD_DISABLED && enable_wr_i && enable_val_i) |=> (count_o == $past(init_load));
    endproperty
    a_enable_loads: assert property (p_enable_loads) else $error("enable did not load init");

    property p_decrement;
        @(posedge clk_sys_i) disable iff (srst_i)
        (enabled_o && !kick && !at_zero && !paused) |=> (count_o == $past(count_o) - 32'h1);
    endproperty
    a_decrement: assert property (p_decrement) else $error("counter did not decrement");

    property p_pause_hold;
        @(posedge clk_sys_i) disable iff (srst_i)
        (enabled_o && paused && !kick && !at_zero) |=> $stable(count_o);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("counter moved while paused");

    property p_kick_reload;
        @(posedge clk_sys_i) disable iff (srst_i)
        (enabled_o && kick) |=> (count_o == $past(restart_load) && !irq_o);
    endproperty
    a_kick_reload: assert property (p_kick_reload) else $error("restart did not reload");

    property p_bad_key;
        @(posedge clk_sys_i) disable iff (srst_i)
        (enabled_o && restart_wr_i && restart_data_i != SWD_RESTART_KEY && !eoi_rd_i
         && !at_zero && !paused) |=> (count_o == $past(count_o) - 32'h1);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("wrong key reloaded");

    property p_reset_mode;
        @(posedge clk_sys_i) disable iff (srst_i)
        (enabled_o && at_zero && !kick && mode_i == SWD_MODE_RESET) |=> rst_req_o;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("no reset request");

    property p_irq_first;
        @(posedge clk_sys_i) disable iff (srst_i)
        (r.st == SWD_FIRST && at_zero && !kick && mode_i == SWD_MODE_IRQ)
            |=> (irq_o && !rst_req_o && count_o == $past(restart_load));
    endproperty
    a_irq_first: assert property (p_irq_first) else $error("first timeout wrong");

    property p_second;
        @(posedge clk_sys_i) disable iff (srst_i)
        (r.st == SWD_SECOND && at_zero && !kick) |=> rst_req_o;
    endproperty
    a_second: assert property (p_second) else $error("second timeout no reset");

    property p_kick_wins;
        @(posedge clk_sys_i) disable iff (srst_i)
        (enabled_o && at_zero && kick) |=> (!irq_o && $stable(rst_req_o));
    endproperty
    a_kick_wins: assert property (p_kick_wins) else $error("restart lost to timeout");

    property p_stay_on;
        @(posedge clk_sys_i) disable iff (srst_i)
        enabled_o |=> enabled_o;
    endproperty
    a_stay_on: assert property (p_stay_on) else $error("watchdog disabled");

    property p_irq_hold;
        @(posedge clk_sys_i) disable iff (srst_i)
        (irq_o && !kick) |=> irq_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");

    // reset request is sticky; only the reset manager takes it back
    property p_rst_sticky;
        @(posedge clk_sys_i) disable iff (srst_i)
        rst_req_o |=> rst_req_o;
    endproperty
    a_rst_sticky: assert property (p_rst_sticky) else $error("reset request dropped");

    property p_idle;
        @(posedge clk_sys_i) disable iff (srst_i)
        (!enabled_o && !(enable_wr_i && enable_val_i))
            |=> (!enabled_o && count_o == SWD_CNT_RST && !irq_o && !rst_req_o);
    endproperty
    a_idle: assert property (p_idle) else $error("disabled watchdog not idle");

    property p_irq_mode;
        @(posedge clk_sys_i) disable iff (srst_i)
        $rose(irq_o) |-> ($past(mode_i) == SWD_MODE_IRQ);
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("interrupt in reset mode");

    c_second: cover property (@(posedge clk_sys_i) disable iff (srst_i)
        r.st == SWD_SECOND && at_zero && !kick);

    c_enable: cover property (@(posedge clk_sys_i) disable iff (srst_i) $rose(enabled_o));
    c_irq: cover property (@(posedge clk_sys_i) disable iff (srst_i) $rose(irq_o));
    c_rst: cover property (@(posedge clk_sys_i) disable iff (srst_i) $rose(rst_req_o));
    c_kick_zero: cover property (@(posedge clk_sys_i) disable iff (srst_i)
        enabled_o && at_zero && kick);
endmodule // swd_watchdog

//--- dv/swd_pause_model.sv
// debug pause source model for the watchdog bench
`timescale 1ns/1ps
module swd_pause_model
(
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    input  wire logic       cfg_wr_i,
    input  wire logic [2:0] cfg_i,
    input  wire logic [3:0] dbg_i,
    output logic            pause_o
);
    logic [2:0] cfg;
    // 0 any processor, 1..4 one processor, 5..7 never
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            cfg <= 3'h0;
        else if (cfg_wr_i)
            cfg <= cfg_i;
    end
    always_comb
    begin
        if (cfg == 3'h0)
            pause_o = |dbg_i;
        else if (cfg <= 3'h4)
            pause_o = dbg_i[2'(cfg - 3'h1)];
        else
            pause_o = 1'b0;
    end
endmodule // swd_pause_model

//--- dv/testbench.sv
// self-checking bench for the system watchdog timer
`timescale 1ns/1ps
module testbench
    import swd_pkg::*;
;
    logic clk_sys_i = 0, srst_i = 1, en_wr = 0, en_val = 0, mode = 0;
    logic [3:0] top_init = 0, top = 0, dbg = 0;
    logic kick = 0, eoi = 0, cfg_wr = 0, pause, enabled, irq, rst_req;
    logic [2:0] cfg = 0;
    logic [7:0] key = 0;
    logic [31:0] count, c;
    int errors = 0, n_checks = 0, seed = 32'h2e10, n;
    swd_pause_model swd_pause_model_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .cfg_wr_i(cfg_wr), .cfg_i(cfg), .dbg_i(dbg), .pause_o(pause));
    swd_watchdog swd_watchdog_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .enable_wr_i(en_wr), .enable_val_i(en_val), .mode_i(mode),
        .top_init_i(top_init), .top_i(top), .restart_wr_i(kick),
        .restart_data_i(key), .eoi_rd_i(eoi), .pause_i(pause),
        .enabled_o(enabled), .count_o(count), .irq_o(irq), .rst_req_o(rst_req));
    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [31:0] ld(input logic [3:0] i);
        ld = (32'h1 << (SWD_TOP_BASE + i)) - 32'h1;
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one cycle restart write; answer is sampled right after its edge
    task automatic do_kick(input logic [7:0] k);
        kick = 1;
        key = k;
        tick(1);
        kick = 0;
    endtask
    // pause goes through a 3 flop sync, so let it settle before sampling
    task automatic pchk(input logic [2:0] sel, input logic [3:0] d, input logic held);
        cfg = sel;
        cfg_wr = 1;
        dbg = d;
        tick(1);
        cfg_wr = 0;
        tick(5);
        c = count;
        tick(3);
        chk(count, held ? c : c - 32'h3);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        tick(8);
        srst_i = 0;
        chk({enabled, irq, rst_req}, 32'h0);
        chk(count, SWD_CNT_RST);
        do_kick(SWD_RESTART_KEY);
        chk(count, SWD_CNT_RST);
        top = 4'($random(seed));
        en_wr = 1;
        en_val = 1;
        tick(1);
        en_wr = 0;
        chk(enabled, 1'b1);
        chk(count, ld(top_init));
        tick(1);
        chk(count, ld(top_init) - 32'h1);
        en_wr = 1;
        en_val = 0;
        tick(1);
        en_wr = 0;
        chk(enabled, 1'b1);
        c = count;
        key = 8'($random(seed));
        do_kick((key == SWD_RESTART_KEY) ? 8'h00 : key);
        chk(count, c - 32'h1);
        for (n = 0; n < 3; n++)
        begin
            top = (n == 2) ? 4'h0 : 4'($random(seed));
            do_kick(SWD_RESTART_KEY);
            chk(count, ld(top));
        end
        pchk(3'h0, 4'h8, 1'b1);
        pchk(3'h4, 4'h8, 1'b1);
        pchk(3'h1, 4'h8, 1'b0);
        pchk(3'h5, 4'hf, 1'b0);
        dbg = 0;
        mode = SWD_MODE_IRQ;
        n = 0;
        while (count !== 32'h0 && n < 70000)
        begin
            tick(1);
            n++;
        end
        chk(irq, 1'b0);
        tick(1);
        chk({irq, rst_req}, 32'h2);
        chk(count, ld(top));
        tick(4);
        chk(irq, 1'b1);
        eoi = 1;
        tick(1);
        eoi = 0;
        chk(irq, 1'b0);
        chk(count, ld(top));
        // a reset in mid-run is the only way to stop a running watchdog
        srst_i = 1;
        tick(2);
        srst_i = 0;
        chk({enabled, irq, rst_req}, 32'h0);
        chk(count, SWD_CNT_RST);
        tick(2);
        chk({enabled, count}, 33'h0);
        conclude();
    end
    initial
    begin
        tick(90000);
        errors++;
        conclude();
    end
endmodule // testbench
